// file: rtl/ltt_top.sv
// Training timers and state sequencing with lane mapping
`timescale 1ns/1ps
module ltt_top #(
  parameter bit         SIM_SHORTEN = 1'b0,
  parameter int         CYC_IDLE_N  = ltt_pkg::CYC_IDLE,
  parameter int         CYC_MID_N   = ltt_pkg::CYC_MID,
  parameter int         CYC_LONG_N  = ltt_pkg::CYC_LONG
) (
  input  wire logic                                           i_mclk,
  input  wire logic                                           i_sys_rst,
  input  wire logic                                           i_flip_lanes,
  input  wire logic [ltt_pkg::NUM_LANES*ltt_pkg::LANE_W-1:0] i_phy_data,
  input  wire logic [ltt_pkg::NUM_LANES-1:0]                  i_lane_used,
  input  wire logic                                           i_cfg_done,
  input  wire logic                                           i_rx_detected,
  input  wire logic                                           i_ts_sent,
  input  wire logic                                           i_ts_rx_ok,
  input  wire logic                                           i_eios_rx,
  input  wire logic                                           i_idle_seen,
  input  wire logic                                           i_loopback_req,
  input  wire logic                                           i_retrain,
  input  wire logic                                           i_no_train,
  output logic      [ltt_pkg::NUM_LANES*ltt_pkg::LANE_W-1:0] o_lane_data,
  output logic      [ltt_pkg::NUM_LANES-1:0]                  o_chan_pd,
  output logic      [3:0]                                     o_ltssm_state,
  output logic                                                o_timeout,
  output logic                                                o_idle_expired
);
  typedef enum {S_DETECT, S_POLL_ACT, S_POLL_CFG, S_CFG_LW, S_L0, S_RCV_LOCK, S_RCV_CFG, S_LOOPBACK} st_t;

  localparam int IDLE_LIM = SIM_SHORTEN ? ltt_pkg::CYC_IDLE_SIM : CYC_IDLE_N;
  localparam int MID_LIM  = SIM_SHORTEN ? ltt_pkg::CYC_MID_SIM  : CYC_MID_N;
  localparam int LONG_LIM = SIM_SHORTEN ? ltt_pkg::CYC_LONG_SIM : CYC_LONG_N;
  localparam int SET_LIM  = SIM_SHORTEN ? ltt_pkg::SETS_POLL_SIM : ltt_pkg::SETS_POLL;
  localparam logic [ltt_pkg::CNT_W-1:0] IDLE_L = IDLE_LIM[ltt_pkg::CNT_W-1:0];
  localparam logic [ltt_pkg::CNT_W-1:0] MID_L  = MID_LIM[ltt_pkg::CNT_W-1:0];
  localparam logic [ltt_pkg::CNT_W-1:0] LONG_L = LONG_LIM[ltt_pkg::CNT_W-1:0];
  localparam logic [ltt_pkg::CNT_W-1:0] SET_L  = SET_LIM[ltt_pkg::CNT_W-1:0];
  localparam logic [ltt_pkg::CNT_W-1:0] ONE    = 24'h00_0001;

  // ******************************************************
  // Input synchroniser for i_cfg_done
  // ******************************************************
  logic [2:0] cfg_sync_ff;
  logic [2:0] nxt_cfg_sync_ff;
  logic       cfg_ok;
  logic       cfg_ok_ff;
  logic       nxt_cfg_ok_ff;
  always_comb begin
    nxt_cfg_sync_ff = {cfg_sync_ff[1:0], i_cfg_done};
    // Level only changes once the two late stages agree
    cfg_ok          = (cfg_sync_ff[2] == cfg_sync_ff[1]) ? cfg_sync_ff[2] : cfg_ok_ff;
    nxt_cfg_ok_ff   = cfg_ok;
  end
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cfg_sync_ff <= 3'h0;
      cfg_ok_ff   <= 1'b0;
    end else begin
      cfg_sync_ff <= nxt_cfg_sync_ff;
      cfg_ok_ff   <= nxt_cfg_ok_ff;
    end
  end

  // ******************************************************
  // Lane mapping
  // ******************************************************
  ltt_lane_map u_map (
    .i_mclk      (i_mclk),
    .i_sys_rst   (i_sys_rst),
    .i_flip      (i_flip_lanes),
    .i_phy_data  (i_phy_data),
    .i_lane_used (i_lane_used),
    .o_lane_data (o_lane_data),
    .o_chan_pd   (o_chan_pd)
  );

  // ******************************************************
  // State machine and timers
  // ******************************************************
  st_t                     st_ff;
  st_t                     nxt_st_ff;
  logic [ltt_pkg::CNT_W-1:0] tmr_ff;
  logic [ltt_pkg::CNT_W-1:0] nxt_tmr_ff;
  logic [ltt_pkg::CNT_W-1:0] set_ff;
  logic [ltt_pkg::CNT_W-1:0] nxt_set_ff;
  logic [ltt_pkg::CNT_W-1:0] idle_ff;
  logic [ltt_pkg::CNT_W-1:0] nxt_idle_ff;
  logic                    idle_run_ff;
  logic                    nxt_idle_run_ff;
  logic                    to_ff;
  logic                    nxt_to_ff;
  logic                    exp_ff;
  logic                    nxt_exp_ff;
  logic [3:0]              enc_ff;
  logic [3:0]              nxt_enc_ff;

  function automatic logic [ltt_pkg::CNT_W-1:0] lim_of(input st_t s);
    unique case (s)
      S_POLL_ACT, S_CFG_LW, S_RCV_LOCK: lim_of = MID_L;
      S_POLL_CFG, S_RCV_CFG:            lim_of = LONG_L;
      default:                          lim_of = '0;
    endcase
  endfunction

  function automatic logic [3:0] enc_of(input st_t s);
    unique case (s)
      S_DETECT:               enc_of = ltt_pkg::ST_DETECT;
      S_POLL_ACT, S_POLL_CFG: enc_of = ltt_pkg::ST_POLLING;
      S_CFG_LW:               enc_of = ltt_pkg::ST_CONFIG;
      S_L0:                   enc_of = ltt_pkg::ST_L0;
      S_RCV_LOCK, S_RCV_CFG:  enc_of = ltt_pkg::ST_RECOVERY;
      S_LOOPBACK:             enc_of = ltt_pkg::ST_LOOPBACK;
    endcase
  endfunction

  logic tmo;
  logic sets_done;
  assign tmo       = (lim_of(st_ff) != '0) && (tmr_ff >= lim_of(st_ff) - ONE);
  assign sets_done = (set_ff >= SET_L);

  always_comb begin
    nxt_st_ff = st_ff;
    unique case (st_ff)
      // Training waits for configuration, whether done before or after release
      S_DETECT:   if (cfg_ok && i_rx_detected) nxt_st_ff = S_POLL_ACT;
      S_POLL_ACT: if (sets_done && i_ts_rx_ok) nxt_st_ff = S_POLL_CFG;
                  else if (tmo) nxt_st_ff = S_DETECT;
      S_POLL_CFG: if (i_ts_rx_ok) nxt_st_ff = S_CFG_LW;
                  else if (tmo) nxt_st_ff = S_DETECT;
      S_CFG_LW:   if (i_no_train || i_ts_rx_ok) nxt_st_ff = S_L0;
                  else if (tmo) nxt_st_ff = S_DETECT;
      S_L0:       if (i_loopback_req) nxt_st_ff = S_LOOPBACK;
                  else if (i_retrain) nxt_st_ff = S_RCV_LOCK;
      S_RCV_LOCK: if (i_ts_rx_ok) nxt_st_ff = S_RCV_CFG;
                  else if (tmo) nxt_st_ff = S_DETECT;
      S_RCV_CFG:  if (i_ts_rx_ok) nxt_st_ff = S_L0;
                  else if (tmo) nxt_st_ff = S_DETECT;
      S_LOOPBACK: if (exp_ff) nxt_st_ff = S_DETECT;
    endcase
    if (!cfg_ok) nxt_st_ff = S_DETECT;

    nxt_tmr_ff = (nxt_st_ff != st_ff) ? '0 : tmr_ff + ONE;
    nxt_set_ff = (st_ff != S_POLL_ACT || nxt_st_ff != S_POLL_ACT) ? '0 :
                 (i_ts_sent && !sets_done) ? set_ff + ONE : set_ff;
    nxt_to_ff  = tmo && (nxt_st_ff == S_DETECT);

    // Loopback slave idle interval
    nxt_idle_run_ff = idle_run_ff;
    nxt_idle_ff     = idle_ff;
    nxt_exp_ff      = 1'b0;
    if (st_ff != S_LOOPBACK) begin
      nxt_idle_run_ff = 1'b0;
      nxt_idle_ff     = '0;
    end else if (idle_run_ff) begin
      nxt_idle_ff = idle_ff + ONE;
      if (i_idle_seen || idle_ff >= IDLE_L - ONE) begin
        nxt_exp_ff      = 1'b1;
        nxt_idle_run_ff = 1'b0;
      end
    end else if (i_eios_rx) begin
      nxt_idle_run_ff = 1'b1;
      nxt_idle_ff     = '0;
    end
    nxt_enc_ff = enc_of(nxt_st_ff);
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_ff       <= S_DETECT;
      tmr_ff      <= '0;
      set_ff      <= '0;
      idle_ff     <= '0;
      idle_run_ff <= 1'b0;
      to_ff       <= 1'b0;
      exp_ff      <= 1'b0;
      enc_ff      <= ltt_pkg::ST_DETECT;
    end else begin
      st_ff       <= nxt_st_ff;
      tmr_ff      <= nxt_tmr_ff;
      set_ff      <= nxt_set_ff;
      idle_ff     <= nxt_idle_ff;
      idle_run_ff <= nxt_idle_run_ff;
      to_ff       <= nxt_to_ff;
      exp_ff      <= nxt_exp_ff;
      enc_ff      <= nxt_enc_ff;
    end
  end

  assign o_ltssm_state  = enc_ff;
  assign o_timeout      = to_ff;
  assign o_idle_expired = exp_ff;

  // ******************************************************
  // Checks
  // ******************************************************
  a_mid_limit: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff == S_POLL_ACT && tmr_ff == MID_L - ONE && !(sets_done && i_ts_rx_ok) && cfg_ok)
      |=> st_ff == S_DETECT ##0 o_timeout)
    else $error("mid timeout missed");
  a_long_limit: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ((st_ff == S_POLL_CFG || st_ff == S_RCV_CFG) && tmr_ff == LONG_L - ONE && !i_ts_rx_ok && cfg_ok)
      |=> st_ff == S_DETECT)
    else $error("long timeout missed");
  a_no_early: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    o_timeout |-> $past(tmr_ff) == lim_of($past(st_ff)) - ONE)
    else $error("timeout at wrong count");
  a_set_count: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff == S_POLL_ACT && nxt_st_ff == S_POLL_CFG) |-> set_ff == SET_L)
    else $error("left polling early");
  a_wait_cfg: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !cfg_ok |=> o_ltssm_state == ltt_pkg::ST_DETECT)
    else $error("trained without config");
  a_det_poll: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff == S_DETECT && cfg_ok && i_rx_detected) |=> o_ltssm_state == ltt_pkg::ST_POLLING)
    else $error("detect did not advance");
  a_idle_expire: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (idle_run_ff && st_ff == S_LOOPBACK && idle_ff == IDLE_L - ONE) |=> o_idle_expired)
    else $error("idle interval not timed");
  a_force_l0: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (st_ff == S_CFG_LW && i_no_train && cfg_ok) |=> o_ltssm_state == ltt_pkg::ST_L0)
    else $error("no-training not honoured");
endmodule // ltt_top

// file: pkg/ltt_pkg.sv
// Constants for lane mapping and training timers
package ltt_pkg;
  localparam int NUM_LANES = 4;
  localparam int LANE_W = 10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_IDLE_MS = 1;
  localparam int T_IDLE_SIM_NS = 800;
  localparam int T_MID_MS = 24;
  localparam int T_MID_SIM_NS = 1600;
  localparam int T_LONG_MS = 48;
  localparam int T_LONG_SIM_NS = 3200;
  localparam int NS_PER_MS = 1000000;
  localparam int CYC_IDLE = T_IDLE_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int CYC_IDLE_SIM = T_IDLE_SIM_NS / CLK_PERIOD_NS;
  localparam int CYC_MID = T_MID_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int CYC_MID_SIM = T_MID_SIM_NS / CLK_PERIOD_NS;
  localparam int CYC_LONG = T_LONG_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int CYC_LONG_SIM = T_LONG_SIM_NS / CLK_PERIOD_NS;
  localparam int SETS_POLL = 1024;
  localparam int SETS_POLL_SIM = 48;
  localparam int CNT_W = 24;
  localparam logic [3:0] ST_DETECT = 4'h0;
  localparam logic [3:0] ST_POLLING = 4'h1;
  localparam logic [3:0] ST_CONFIG = 4'h2;
  localparam logic [3:0] ST_L0 = 4'h3;
  localparam logic [3:0] ST_RECOVERY = 4'h4;
  localparam logic [3:0] ST_LOOPBACK = 4'h5;
endpackage

// file: rtl/ltt_lane_map.sv
// Lane reversal mux between transceiver channels and logical lanes
`timescale 1ns/1ps
module ltt_lane_map (
  input  wire logic                                           i_mclk,
  input  wire logic                                           i_sys_rst,
  input  wire logic                                           i_flip,
  input  wire logic [ltt_pkg::NUM_LANES*ltt_pkg::LANE_W-1:0] i_phy_data,
  input  wire logic [ltt_pkg::NUM_LANES-1:0]                  i_lane_used,
  output logic      [ltt_pkg::NUM_LANES*ltt_pkg::LANE_W-1:0] o_lane_data,
  output logic      [ltt_pkg::NUM_LANES-1:0]                  o_chan_pd
);
  logic [ltt_pkg::NUM_LANES*ltt_pkg::LANE_W-1:0] nxt_lane_ff;
  logic [ltt_pkg::NUM_LANES*ltt_pkg::LANE_W-1:0] lane_ff;
  logic [ltt_pkg::NUM_LANES-1:0]                  nxt_pd_ff;
  logic [ltt_pkg::NUM_LANES-1:0]                  pd_ff;

  genvar g;
  generate
    for (g = 0; g < ltt_pkg::NUM_LANES; g++) begin : g_lane
      localparam int R = ltt_pkg::NUM_LANES - 1 - g;
      assign nxt_lane_ff[g*ltt_pkg::LANE_W +: ltt_pkg::LANE_W] = i_flip ?
        i_phy_data[R*ltt_pkg::LANE_W +: ltt_pkg::LANE_W] :
        i_phy_data[g*ltt_pkg::LANE_W +: ltt_pkg::LANE_W];
      // Channel carrying a used logical lane stays powered
      assign nxt_pd_ff[g] = i_flip ? ~i_lane_used[R] : ~i_lane_used[g];
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      lane_ff <= '0;
      pd_ff   <= '1;
    end else begin
      lane_ff <= nxt_lane_ff;
      pd_ff   <= nxt_pd_ff;
    end
  end

  assign o_lane_data = lane_ff;
  assign o_chan_pd   = pd_ff;

  a_lane_rev: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_flip |=> o_lane_data[ltt_pkg::LANE_W-1:0] ==
      $past(i_phy_data[(ltt_pkg::NUM_LANES-1)*ltt_pkg::LANE_W +: ltt_pkg::LANE_W]))
    else $error("reversed lane 0 wrong");
  a_lane_str: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !i_flip |=> o_lane_data == $past(i_phy_data))
    else $error("straight mapping wrong");
  a_chan_pd: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (!i_flip && !i_lane_used[ltt_pkg::NUM_LANES-1]) |=> o_chan_pd[ltt_pkg::NUM_LANES-1])
    else $error("unused channel powered");
endmodule // ltt_lane_map

// file: test/ltt_partner.sv
// Link partner model driving the far side of training
`timescale 1ns/1ps
module ltt_partner (
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire logic [3:0] i_state,
  input  wire logic [7:0] i_ts_budget,
  output logic            o_rx_detected,
  output logic            o_ts_sent,
  output logic            o_ts_rx_ok,
  output logic            o_no_train
);
  logic [7:0] sent;

  // ****************************************
  // Partner follows the device through training
  // ****************************************
  always @(negedge i_mclk) begin
    o_rx_detected <= !i_sys_rst; // Termination seen, partner heads to Polling
    o_no_train    <= (i_state == ltt_pkg::ST_CONFIG); // Force L0 once in Config
    if (i_state == ltt_pkg::ST_POLLING) begin // Train together with the device
      o_ts_rx_ok <= (i_ts_budget != 8'h00);
      o_ts_sent  <= (sent < i_ts_budget);
      sent       <= sent + ((sent < i_ts_budget) ? 8'h01 : 8'h00);
    end else if (i_state == ltt_pkg::ST_RECOVERY) begin // One lock answer, then silence
      o_ts_rx_ok <= (i_ts_budget != 8'h00) && (sent == 8'h00);
      o_ts_sent  <= 1'b0;
      sent       <= 8'h01;
    end else begin
      o_ts_rx_ok <= 1'b0;
      o_ts_sent  <= 1'b0;
      sent       <= 8'h00;
    end
  end
endmodule // ltt_partner

// file: test/link_training_timers_lane_reversal_test.sv
// Self-checking bench for lane mapping and training timers
`timescale 1ns/1ps
module link_training_timers_lane_reversal_test;
  localparam int MID_CYC  = 160;  // 1600 ns at 10 ns
  localparam int LONG_CYC = 320;  // 3200 ns at 10 ns
  localparam int IDLE_CYC = 80;   // 800 ns at 10 ns
  logic        i_mclk, i_sys_rst, i_flip_lanes, i_cfg_done, i_eios_rx, i_loopback_req, i_idle_seen, i_retrain;
  logic [39:0] i_phy_data, o_lane_data;
  logic [3:0]  i_lane_used, o_chan_pd, o_ltssm_state;
  logic        rx_det, ts_sent, ts_ok, no_train, o_timeout, o_idle_expired;
  logic [7:0]  ts_budget;
  int          num_errors, total_checks, cycles;

  ltt_top #(.SIM_SHORTEN(1'b1)) dut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_flip_lanes(i_flip_lanes), .i_phy_data(i_phy_data),
    .i_lane_used(i_lane_used), .i_cfg_done(i_cfg_done), .i_rx_detected(rx_det), .i_ts_sent(ts_sent),
    .i_ts_rx_ok(ts_ok), .i_eios_rx(i_eios_rx), .i_idle_seen(i_idle_seen), .i_loopback_req(i_loopback_req),
    .i_retrain(i_retrain), .i_no_train(no_train), .o_lane_data(o_lane_data), .o_chan_pd(o_chan_pd),
    .o_ltssm_state(o_ltssm_state), .o_timeout(o_timeout), .o_idle_expired(o_idle_expired));

  ltt_partner partner (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_state(o_ltssm_state), .i_ts_budget(ts_budget),
    .o_rx_detected(rx_det), .o_ts_sent(ts_sent), .o_ts_rx_ok(ts_ok), .o_no_train(no_train));

  // ****************************************
  // Clock, watchdog and reporting
  // ****************************************
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wait_state(input logic [3:0] s, input int lim);
    int n;
    n = 0;
    while (o_ltssm_state !== s && n < lim) begin
      @(negedge i_mclk);
      n++;
    end
  endtask

  task automatic do_reset;
    i_sys_rst = 1'b1;
    repeat (10) @(negedge i_mclk); // Host holds reset, scaled down
    cmp(o_ltssm_state, ltt_pkg::ST_DETECT);
    cmp(o_chan_pd, 4'hf);
    cmp(o_lane_data, 40'h00_0000_0000);
    i_sys_rst = 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_lanes;
    i_phy_data  = 40'h01_0030_0801;
    i_lane_used = 4'h1;
    for (int f = 0; f < 2; f++) begin
      i_flip_lanes = f[0];
      repeat (2) @(negedge i_mclk);
      cmp(o_lane_data, f[0] ? 40'h00_4020_0c04 : 40'h01_0030_0801);
      cmp(o_chan_pd, f[0] ? 4'h7 : 4'he);
    end
  endtask

  task automatic t_late_cfg;
    int n;
    i_cfg_done = 1'b0;
    ts_budget  = 8'h2f;
    do_reset();
    repeat (20) @(negedge i_mclk);
    cmp(o_ltssm_state, ltt_pkg::ST_DETECT);
    i_cfg_done = 1'b1;
    wait_state(ltt_pkg::ST_POLLING, 10);
    cmp(o_ltssm_state, ltt_pkg::ST_POLLING);
    n = 0;
    while (o_ltssm_state === ltt_pkg::ST_POLLING && n < 400) begin
      @(negedge i_mclk);
      n++;
    end
    cmp(n, MID_CYC); // One set short of the count, so the timer fires
    cmp(o_timeout, 1'b1);
    cmp(o_ltssm_state, ltt_pkg::ST_DETECT);
  endtask

  task automatic t_link_loop;
    int n;
    ts_budget = 8'h30;
    do_reset(); // Configuration already done at release
    wait_state(ltt_pkg::ST_L0, 400);
    cmp(o_ltssm_state, ltt_pkg::ST_L0);
    i_loopback_req = 1'b1;
    wait_state(ltt_pkg::ST_LOOPBACK, 10);
    i_loopback_req = 1'b0;
    cmp(o_ltssm_state, ltt_pkg::ST_LOOPBACK);
    i_eios_rx = 1'b1;
    @(negedge i_mclk);
    i_eios_rx = 1'b0;
    n = 0;
    while (o_idle_expired !== 1'b1 && n < 300) begin
      @(negedge i_mclk);
      n++;
    end
    cmp(n, IDLE_CYC); // Idle interval of 800 ns
    wait_state(ltt_pkg::ST_DETECT, 2);
    cmp(o_ltssm_state, ltt_pkg::ST_DETECT);
  endtask

  task automatic t_recovery;
    int n;
    for (int k = 0; k < 2; k++) begin
      ts_budget = 8'h30;
      wait_state(ltt_pkg::ST_L0, 400);
      cmp(o_ltssm_state, ltt_pkg::ST_L0);
      ts_budget = k[0] ? 8'h30 : 8'h00; // Partner answers lock only with a budget
      i_retrain = 1'b1;
      wait_state(ltt_pkg::ST_RECOVERY, 10);
      i_retrain = 1'b0;
      n = 0;
      while (o_ltssm_state === ltt_pkg::ST_RECOVERY && n < 600) begin
        @(negedge i_mclk);
        n++;
      end
      cmp(n, k[0] ? LONG_CYC + 1 : MID_CYC); // Lock timeout, or one lock cycle then cfg timeout
      cmp(o_timeout, 1'b1);
    end
  endtask

  task automatic t_idle_seen;
    ts_budget = 8'h30;
    wait_state(ltt_pkg::ST_L0, 400);
    i_loopback_req = 1'b1;
    wait_state(ltt_pkg::ST_LOOPBACK, 10);
    i_loopback_req = 1'b0;
    i_eios_rx = 1'b1;
    @(negedge i_mclk);
    i_eios_rx   = 1'b0;
    i_idle_seen = 1'b1;
    @(negedge i_mclk);
    i_idle_seen = 1'b0;
    cmp(o_idle_expired, 1'b1); // Idle seen ends the interval early
    wait_state(ltt_pkg::ST_DETECT, 2);
    cmp(o_ltssm_state, ltt_pkg::ST_DETECT);
  endtask

  initial begin
    num_errors     = 0;
    total_checks   = 0;
    cycles         = 0;
    i_sys_rst      = 1'b1;
    i_flip_lanes   = 1'b0;
    i_phy_data     = 40'h00_0000_0000;
    i_lane_used    = 4'hf;
    i_cfg_done     = 1'b0;
    i_eios_rx      = 1'b0;
    i_loopback_req = 1'b0;
    i_idle_seen    = 1'b0;
    i_retrain      = 1'b0;
    ts_budget      = 8'h00;
    @(negedge i_mclk);
    do_reset();
    t_lanes();
    t_late_cfg();
    t_link_loop();
    t_recovery();
    t_idle_seen();
    summarize();
  end
endmodule // link_training_timers_lane_reversal_test
